/* File: bci_ctl_model.sv */
// Bus controller model: sends addressing and data bytes, takes reading bytes.
// Assumes the interpreter samples every byte and handshake on rising clk_sys.
`timescale 1ns/100ps
`default_nettype none

module bci_ctl (
    input  wire logic       clk_sys,
    output logic            rx_valid,
    output logic            rx_atn,
    output logic [7:0]      rx_data,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    // Idle bus at time zero
    initial begin
        rx_valid = 1'b0;
        rx_atn   = 1'b0;
        rx_data  = 8'hA5;
        tx_ready = 1'b0;
    end

    // One pulse per byte; lines show the inverse after, as nothing holds them
    task automatic put_byte(input logic atn, input logic [7:0] d);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_atn   <= atn;
        rx_data  <= d;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_atn   <= 1'b0;
        rx_data  <= ~d;
    endtask

    // Take 19 bytes, stalling a varying time so each byte must stand
    task automatic get_bytes(output logic [7:0] got [19], output bit ok);
        int w;
        ok = 1'b1;
        for (int i = 0; i < 19; i++) begin
            w = 0;
            do begin
                @(posedge clk_sys);
                #1 w++;
            end while (tx_valid !== 1'b1 && w < 40);
            if (w >= 40) begin
                ok = 1'b0;
                return;
            end
            got[i] = tx_data;
            repeat (i % 3) @(posedge clk_sys);
            @(posedge clk_sys);
            tx_ready <= 1'b1;
            @(posedge clk_sys);
            tx_ready <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: bci_fmt.sv */
// Reading string formatter: emits one reading as ASCII bytes on a
// valid/ready stream. Assumes the reading input is valid in the start cycle.
`timescale 1ns/100ps
`default_nettype none

module bci_fmt (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            start,
    input  wire bci_pkg::bci_rdg_t rdg,
    output logic                 tx_valid,
    input  wire logic            tx_ready,
    output logic [7:0]           tx_data
);

    logic [4:0]        idx_q;
    logic              busy_q;
    bci_pkg::bci_rdg_t rdg_q;

    function automatic logic [7:0] bcd_char(input logic [3:0] d);
        bcd_char = bci_pkg::CH_ZERO | {4'h0, d};
    endfunction

    // Latch the reading at start so the string is self-consistent
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'h0;
            idx_q  <= 5'h00;
            rdg_q  <= '0;
        end else if (start) begin
            busy_q <= 1'h1;
            idx_q  <= 5'h00;
            rdg_q  <= rdg;
        end else if (busy_q && tx_ready) begin
            idx_q  <= idx_q + 5'h01;
            busy_q <= (idx_q != bci_pkg::STR_LEN - 5'h01);
        end
    end

    // Character selection, prefix then signed mantissa and exponent
    always_comb begin
        case (idx_q)
            5'h00: tx_data = bci_pkg::CH_N; // RULE10
            5'h01: tx_data = bci_pkg::CH_D;
            5'h02: tx_data = bci_pkg::CH_C;
            5'h03: tx_data = bci_pkg::CH_V;
            5'h04: tx_data = rdg_q.neg ? bci_pkg::CH_MINUS : bci_pkg::CH_PLUS;
            5'h05: tx_data = bcd_char(rdg_q.mant[27:24]);
            5'h06: tx_data = bci_pkg::CH_DOT;
            5'h07: tx_data = bcd_char(rdg_q.mant[23:20]);
            5'h08: tx_data = bcd_char(rdg_q.mant[19:16]);
            5'h09: tx_data = bcd_char(rdg_q.mant[15:12]);
            5'h0A: tx_data = bcd_char(rdg_q.mant[11:8]);
            5'h0B: tx_data = bcd_char(rdg_q.mant[7:4]);
            5'h0C: tx_data = bcd_char(rdg_q.mant[3:0]);
            5'h0D: tx_data = bci_pkg::CH_E;
            5'h0E: tx_data = rdg_q.exp_neg ? bci_pkg::CH_MINUS : bci_pkg::CH_PLUS;
            5'h0F: tx_data = bcd_char(rdg_q.expo[7:4]);
            5'h10: tx_data = bcd_char(rdg_q.expo[3:0]);
            5'h11: tx_data = bci_pkg::CH_CR;
            default: tx_data = bci_pkg::CH_LF;
        endcase
    end

    assign tx_valid = busy_q;

    a_str_prefix: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
        start |=> (tx_valid && tx_data == bci_pkg::CH_N))
        else $error("reading string does not open with its prefix");

endmodule

`default_nettype wire

/* File: bci_pkg.sv */
// Package for the bus command interpreter: settings layout, reset defaults,
// listener/talker addressing bytes, command characters and register offsets.
// Assumes bytes arrive already handshaken from an IEEE-488 bus front end.
package bci_pkg;

    // Active and staged instrument settings
    typedef struct packed {
        logic [1:0] res;    // Display resolution option
        logic       damp;   // Filter damping
        logic       filt;   // Master filter enable
        logic       afilt;  // Analog filter
        logic [1:0] dfilt;  // Digital filter response
        logic [2:0] rng;    // Manual range, 1 = 3mV .. 5 = 30V
        logic       autor;  // Auto-ranging enabled
        logic [1:0] integ;  // Integration rate
        logic       rel;    // Reading relative enabled
    } bci_set_t;

    // Result of applying one command to the staged settings
    typedef struct packed {
        logic     ok;
        bci_set_t set;
    } bci_app_t;

    // Reading from the measurement side, BCD digits, most significant first
    typedef struct packed {
        logic        neg;
        logic [27:0] mant;
        logic        exp_neg;
        logic [7:0]  expo;
    } bci_rdg_t;

    localparam bci_set_t SET_RST = '{res: 2'h1, damp: 1'h0, filt: 1'h1, afilt: 1'h0, dfilt: 2'h2,
                                     rng: 3'h5, autor: 1'h0, integ: 2'h0, rel: 1'h0};
    localparam logic [4:0] PA_RST = 5'h07;
    localparam logic [4:0] PA_MAX = 5'h1E;

    // Bus addressing bytes, seven bits
    localparam logic [6:0] LAD_BASE = 7'h20;
    localparam logic [6:0] TAD_BASE = 7'h40;
    localparam logic [6:0] UNL      = 7'h3F;
    localparam logic [6:0] UNT      = 7'h5F;

    // Command and reading string characters
    localparam logic [7:0] CH_EXEC  = 8'h58;
    localparam logic [7:0] CH_B     = 8'h42;
    localparam logic [7:0] CH_D     = 8'h44;
    localparam logic [7:0] CH_N     = 8'h4E;
    localparam logic [7:0] CH_O     = 8'h4F;
    localparam logic [7:0] CH_P     = 8'h50;
    localparam logic [7:0] CH_R     = 8'h52;
    localparam logic [7:0] CH_S     = 8'h53;
    localparam logic [7:0] CH_Z     = 8'h5A;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_PLUS  = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_DOT   = 8'h2E;
    localparam logic [7:0] CH_E     = 8'h45;
    localparam logic [7:0] CH_C     = 8'h43;
    localparam logic [7:0] CH_V     = 8'h56;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;

    // Reading string length: NDCV s d . dddddd E s ee CR LF
    localparam logic [4:0] STR_LEN  = 5'h13;

    // Register offsets
    localparam logic [3:0] REG_ADDR   = 4'h0;
    localparam logic [3:0] REG_SET    = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_REL    = 4'h3;

    // Status register bit positions
    localparam int ST_LISTEN = 0;
    localparam int ST_TALK   = 1;
    localparam int ST_ERR    = 2;

endpackage

/* File: bci_top.sv */
// Bus command interpreter: listens for its primary address, parses command
// strings into staged settings, applies them on the execute character and
// talks a reading string when addressed to talk.
// Assumes rx bytes are one-cycle pulses from an IEEE-488 handshake front end.
// How it works
// RULE1: Received commands only take effect when the execute character arrives; the Z2 value reaches rel_value as soon as its field ends.
// RULE2: Several commands in one string all apply at the execute character.
// RULE3: Resolution option 0..3 selects 5.5, 6.5, 3.5, 4.5 digits.
// RULE4: Damping, master, analog filter on/off; digital filter off/fast/medium/high.
// RULE5: Range options 1..5 pick 3mV to 30V; 6 and 7 do nothing.
// RULE6: Range 0 enables auto-range; 8 cancels it, keeping the present range.
// RULE7: Relative off, on, comma value, or on with the held value.
// RULE8: Power-up settings are the documented factory defaults.
// RULE9: Respond only at primary address 0..30, default 7.
// RULE10: A talk request returns prefix, signed mantissa and exponent as ASCII.
// RULE11: Commands in one string apply in arrival order; later ones win.
// RULE12: Unknown letters or options are rejected and leave settings unchanged.
`timescale 1ns/100ps
`default_nettype none

module bci_top (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              rx_valid,
    input  wire logic              rx_atn,
    input  wire logic [7:0]        rx_data,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output logic [7:0]             tx_data,
    input  wire bci_pkg::bci_rdg_t rdg,
    input  wire logic [2:0]        present_rng,
    output bci_pkg::bci_set_t      settings,
    output logic signed [31:0]     rel_value,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata
);

    typedef enum {BCI_CMD, BCI_OPT, BCI_COMMA, BCI_VAL} bci_st_t;

    bci_st_t            st_q;
    bci_pkg::bci_set_t  active_q;
    bci_pkg::bci_set_t  stage_q;
    bci_pkg::bci_app_t  app;
    logic [7:0]         cmd_q;
    logic [7:0]         ch;
    logic [4:0]         pa_q;
    logic               listen_q;
    logic               talk_q;
    logic               start_q;
    logic               err_q;
    logic               seen_q;
    logic signed [31:0] rel_q;
    logic signed [31:0] acc_q;
    logic               acc_neg_q;
    logic               acc_any_q;
    logic signed [31:0] acc_final;
    logic               data_take;
    logic               cmd_char;
    logic               bad_evt;
    logic               fmt_valid;
    logic [31:0]        rdata_q;

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= bci_pkg::CH_ZERO) && (c <= 8'h39);
    endfunction

    function automatic logic is_letter(input logic [7:0] c);
        is_letter = (c >= 8'h41) && (c <= 8'h5A);
    endfunction

    // Apply one command letter and option digit to a settings copy
    function automatic bci_pkg::bci_app_t apply(input bci_pkg::bci_set_t s, input logic [7:0] c,
                                                input logic [3:0] d, input logic [2:0] pr);
        apply.ok  = 1'h1;
        apply.set = s;
        case (c)
            bci_pkg::CH_B: if (d <= 4'h3) apply.set.res = d[1:0]; else apply.ok = 1'h0; // RULE3
            bci_pkg::CH_D: if (d <= 4'h1) apply.set.damp = d[0]; else apply.ok = 1'h0; // RULE4
            bci_pkg::CH_N: if (d <= 4'h1) apply.set.filt = d[0]; else apply.ok = 1'h0; // RULE4
            bci_pkg::CH_O: if (d <= 4'h1) apply.set.afilt = d[0]; else apply.ok = 1'h0; // RULE4
            bci_pkg::CH_P: if (d <= 4'h3) apply.set.dfilt = d[1:0]; else apply.ok = 1'h0; // RULE4
            bci_pkg::CH_S: if (d <= 4'h2) apply.set.integ = d[1:0]; else apply.ok = 1'h0;
            bci_pkg::CH_R: begin
                if (d == 4'h0) begin
                    apply.set.autor = 1'h1; // RULE6
                end else if (d <= 4'h5) begin
                    apply.set.rng   = d[2:0]; // RULE5
                    apply.set.autor = 1'h0;
                end else if (d == 4'h8) begin
                    apply.set.rng   = pr; // RULE6
                    apply.set.autor = 1'h0;
                end else if (d > 4'h8) begin
                    apply.ok = 1'h0; // Options 6 and 7 pass as no-ops
                end
            end
            bci_pkg::CH_Z: begin
                if (d == 4'h0 || d == 4'h1 || d == 4'h3) apply.set.rel = (d != 4'h0); // RULE7
                else if (d != 4'h2) apply.ok = 1'h0;
            end
            default: apply.ok = 1'h0; // RULE12
        endcase
    endfunction

    // Upper-case letters so lower-case commands are accepted too
    assign ch        = is_letter(rx_data & 8'hDF) ? (rx_data & 8'hDF) : rx_data;
    assign data_take = rx_valid && !rx_atn && listen_q;
    assign cmd_char  = (st_q == BCI_CMD) ||
                       (st_q == BCI_VAL && !is_digit(ch) && ch != bci_pkg::CH_PLUS && ch != bci_pkg::CH_MINUS);
    assign app       = apply(stage_q, cmd_q, rx_data[3:0], present_rng);
    assign acc_final = acc_neg_q ? -acc_q : acc_q;

    // Error event: unknown letter, bad option or malformed value
    always_comb begin
        bad_evt = 1'h0;
        if (data_take) begin
            if (cmd_char)
                bad_evt = !is_letter(ch) && ch != bci_pkg::CH_SPACE && !(st_q == BCI_VAL && ch == bci_pkg::CH_EXEC);
            else if (st_q == BCI_OPT)
                bad_evt = !is_digit(rx_data) || !app.ok;
            else if (st_q == BCI_COMMA)
                bad_evt = (rx_data != bci_pkg::CH_COMMA);
        end
    end

    // Listener/talker addressing; other devices' talk addresses untalk us
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            listen_q <= 1'h0;
            talk_q   <= 1'h0;
            start_q  <= 1'h0;
        end else begin
            start_q <= 1'h0;
            if (rx_valid && rx_atn) begin
                if (rx_data[6:0] == (bci_pkg::LAD_BASE | {2'h0, pa_q})) listen_q <= 1'h1; // RULE9
                else if (rx_data[6:0] == bci_pkg::UNL) listen_q <= 1'h0;
                if (rx_data[6:0] == (bci_pkg::TAD_BASE | {2'h0, pa_q})) begin
                    talk_q  <= 1'h1; // RULE9
                    start_q <= 1'h1;
                end else if (rx_data[6:5] == 2'h2) begin
                    talk_q <= 1'h0; // Covers UNT and other talkers
                end
            end
        end
    end

    // Command parsing into the staged copy; execute copies it to active
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= BCI_CMD;
            cmd_q     <= 8'h00;
            stage_q   <= bci_pkg::SET_RST; // RULE8
            active_q  <= bci_pkg::SET_RST; // RULE8
            rel_q     <= 32'sh0;
            acc_q     <= 32'sh0;
            acc_neg_q <= 1'h0;
            acc_any_q <= 1'h0;
        end else if (data_take) begin
            if (cmd_char) begin
                // Leaving a value field stores it; leaving on a letter or the execute character also turns relative on
                if (st_q == BCI_VAL && acc_any_q) begin
                    rel_q <= acc_final;
                end
                if (ch == bci_pkg::CH_EXEC) begin
                    active_q <= stage_q; // RULE1 RULE2
                    if (st_q == BCI_VAL && acc_any_q) begin
                        active_q.rel <= 1'h1;
                        stage_q.rel  <= 1'h1;
                    end
                    st_q <= BCI_CMD;
                end else if (is_letter(ch)) begin
                    if (st_q == BCI_VAL && acc_any_q) stage_q.rel <= 1'h1;
                    cmd_q <= ch;
                    st_q  <= BCI_OPT;
                end else begin
                    st_q <= BCI_CMD; // Spaces skipped, junk dropped
                end
            end else if (st_q == BCI_OPT) begin
                if (is_digit(rx_data) && app.ok) begin
                    stage_q <= app.set; // RULE11
                end
                st_q <= (cmd_q == bci_pkg::CH_Z && rx_data == 8'h32 && !bad_evt) ? BCI_COMMA : BCI_CMD;
            end else if (st_q == BCI_COMMA) begin
                acc_q     <= 32'sh0;
                acc_neg_q <= 1'h0;
                acc_any_q <= 1'h0;
                st_q      <= bad_evt ? BCI_CMD : BCI_VAL;
            end else begin
                if (is_digit(ch)) begin
                    acc_q     <= 32'(acc_q * 10) + {28'h0, ch[3:0]};
                    acc_any_q <= 1'h1;
                end else if (ch == bci_pkg::CH_MINUS) begin
                    acc_neg_q <= 1'h1;
                end
            end
        end
    end

    // Sticky error flag; a new error wins over a software clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'h0;
        end else if (bad_evt) begin
            err_q <= 1'h1; // RULE12
        end else if (reg_wr && reg_addr == bci_pkg::REG_STATUS && reg_wdata[bci_pkg::ST_ERR]) begin
            err_q <= 1'h0;
        end
    end

    // Primary address; out-of-range writes are ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pa_q <= bci_pkg::PA_RST; // RULE9
        end else if (reg_wr && reg_addr == bci_pkg::REG_ADDR && reg_wdata[31:5] == 27'h0
                     && reg_wdata[4:0] <= bci_pkg::PA_MAX) begin
            pa_q <= reg_wdata[4:0]; // RULE9
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                bci_pkg::REG_ADDR:   rdata_q <= {27'h0, pa_q};
                bci_pkg::REG_SET:    rdata_q <= {18'h0, active_q};
                bci_pkg::REG_STATUS: rdata_q <= {29'h0, err_q, talk_q, listen_q};
                bci_pkg::REG_REL:    rdata_q <= rel_q;
                default:             rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    // Reading output only while addressed to talk and the bus is in data mode
    bci_fmt u_fmt (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .start    (start_q),
        .rdg      (rdg),
        .tx_valid (fmt_valid),
        .tx_ready (tx_ready && talk_q && !rx_atn),
        .tx_data  (tx_data)
    );

    assign tx_valid  = fmt_valid && talk_q && !rx_atn; // RULE10
    assign settings  = active_q;
    assign rel_value = rel_q;
    assign reg_rdata = rdata_q;

    // Marks the first cycle after reset release, for the default check
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) seen_q <= 1'h0;
        else seen_q <= 1'h1;
    end

    a_power_defaults: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        !seen_q |-> (active_q == bci_pkg::SET_RST && pa_q == bci_pkg::PA_RST))
        else $error("settings differ from defaults after reset");
    a_hold_until_exec: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
        (!data_take || ch != bci_pkg::CH_EXEC) |=> active_q == $past(active_q))
        else $error("settings changed without execute");
    a_exec_commit: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        (data_take && ch == bci_pkg::CH_EXEC && st_q == BCI_CMD) |=> active_q == $past(stage_q))
        else $error("execute did not apply staged commands");
    a_res_decode: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_B && rx_data == 8'h33) |=> stage_q.res == 2'h3)
        else $error("resolution option not decoded");
    a_filter_decode: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_P && rx_data == 8'h31) |=> stage_q.dfilt == 2'h1)
        else $error("digital filter option not decoded");
    a_range_manual: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_R && rx_data == 8'h34)
        |=> (stage_q.rng == 3'h4 && !stage_q.autor))
        else $error("manual range not selected");
    a_range_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_R && rx_data == 8'h38)
        |=> (stage_q.rng == $past(present_rng) && !stage_q.autor))
        else $error("auto-range cancel did not keep present range");
    a_rel_decode: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_Z && rx_data == 8'h30) |=> !stage_q.rel)
        else $error("relative off not decoded");
    a_rel_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        (data_take && st_q == BCI_VAL && acc_any_q && cmd_char) |=> rel_q == $past(acc_final))
        else $error("comma value not stored");
    a_range_noop: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_R && rx_data == 8'h36) |=> stage_q == $past(stage_q))
        else $error("range option 6 changed settings");
    a_bad_rejected: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
        (data_take && st_q == BCI_OPT && cmd_q == bci_pkg::CH_B && rx_data == 8'h37)
        |=> (stage_q == $past(stage_q) && err_q))
        else $error("bad option altered settings");
    a_talk_address: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
        $rose(talk_q) |-> $past(rx_valid && rx_atn && rx_data[6:0] == (bci_pkg::TAD_BASE | {2'h0, pa_q})))
        else $error("talker entered at a foreign address");

endmodule

`default_nettype wire

/* File: bci_top_tb_top.sv */
// Testbench for the bus command interpreter, one task per scenario.
// Assumes bci_pkg is compiled first and the controller model sits beside it.
`timescale 1ns/100ps
`default_nettype none

module bci_top_tb_top;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              rx_valid, rx_atn, tx_valid, tx_ready;
    logic [7:0]        rx_data, tx_data;
    logic [2:0]        present_rng = 3'h3;
    logic [3:0]        reg_addr = 4'h0;
    logic [31:0]       reg_wdata = 32'h0, rd;
    logic              reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0]       reg_rdata;
    logic signed [31:0] rel_value;
    bci_pkg::bci_set_t settings, exp_s;
    bci_pkg::bci_rdg_t rdg = '{neg: 1'b0, mant: 28'h1238975, exp_neg: 1'b0, expo: 8'h00};
    logic [4:0]        pa = 5'h07;
    int                failures = 0, total_checks = 0;

    // Clock at 10 MHz
    always #50 clk_sys = ~clk_sys;

    bci_top bci_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_atn(rx_atn),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rdg(rdg),
        .present_rng(present_rng), .settings(settings), .rel_value(rel_value), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    bci_ctl bci_ctl_i (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_atn(rx_atn), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));

    task automatic chk_set(input bci_pkg::bci_set_t g, input bci_pkg::bci_set_t e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: settings %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: value %h expected %h", $time, g, e);
        end
    endtask

    // Expected effect of one command; drawn up from the command table alone
    function automatic bci_pkg::bci_set_t nxt(bci_pkg::bci_set_t s, logic [7:0] l, logic [3:0] d);
        case (l)
            bci_pkg::CH_B: s.res = d[1:0];
            bci_pkg::CH_D: s.damp = d[0];
            bci_pkg::CH_N: s.filt = d[0];
            bci_pkg::CH_O: s.afilt = d[0];
            bci_pkg::CH_P: s.dfilt = d[1:0];
            bci_pkg::CH_S: s.integ = d[1:0];
            bci_pkg::CH_Z: s.rel = (d != 4'h0);
            bci_pkg::CH_R: begin
                if (d == 4'h0) s.autor = 1'b1;
                else if (d == 4'h8) {s.autor, s.rng} = {1'b0, present_rng};
                else if (d <= 4'h5) {s.autor, s.rng} = {1'b0, d[2:0]};
            end
            default: ;
        endcase
        return s;
    endfunction

    // Register bus: one-cycle strobes, read data in the following cycle
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // Data string, then settle time for the applied settings
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) bci_ctl_i.put_byte(1'b0, s[i]);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_exec;
        send_str("R4");
        chk_set(settings, exp_s);
        send_str("X");
        exp_s = nxt(exp_s, bci_pkg::CH_R, 4'h4);
        chk_set(settings, exp_s);
        send_str("R2B0Z1B3");
        chk_set(settings, exp_s);
        send_str("X");
        exp_s = nxt(nxt(nxt(nxt(exp_s, "R", 4'h2), "B", 4'h0), "Z", 4'h1), "B", 4'h3);
        chk_set(settings, exp_s);
    endtask

    // Every option of every command except Z2, each in its own string
    task automatic t_codes;
        string c = "B0B1B2B3D1D0N0N1O1O0P0P1P2P3S1S2S0R1R2R3R4R5R6R7R0R8Z1Z0Z3Z0";
        for (int i = 0; i < c.len(); i += 2) begin
            exp_s = nxt(exp_s, c[i], 4'(c[i+1]));
            send_str({c.substr(i, i + 1), "X"});
            chk_set(settings, exp_s);
        end
    endtask

    // Z2 with a signed value stores it and turns relative on
    task automatic t_rel;
        send_str("Z2,-125X");
        exp_s = nxt(exp_s, "Z", 4'h2);
        chk_set(settings, exp_s);
        chk_val(rel_value, 32'hFFFFFF83);
        reg_read(bci_pkg::REG_REL);
        chk_val(rd, 32'hFFFFFF83);
    endtask

    // Undefined option is dropped and flagged; flag clears by writing one
    task automatic t_err;
        send_str("B7X");
        chk_set(settings, exp_s);
        reg_read(bci_pkg::REG_STATUS);
        chk_val({31'h0, rd[bci_pkg::ST_ERR]}, 32'h1);
        reg_write(bci_pkg::REG_STATUS, 32'h4);
        reg_read(bci_pkg::REG_STATUS);
        chk_val({31'h0, rd[bci_pkg::ST_ERR]}, 32'h0);
    endtask

    // Move to address 30; the old address no longer listens; 31 refused
    task automatic t_addr;
        bci_ctl_i.put_byte(1'b1, bci_pkg::UNL);
        reg_write(bci_pkg::REG_ADDR, 32'h1E);
        bci_ctl_i.put_byte(1'b1, bci_pkg::LAD_BASE | 7'h07);
        send_str("R1X");
        chk_set(settings, exp_s);
        pa = 5'h1E;
        bci_ctl_i.put_byte(1'b1, bci_pkg::LAD_BASE | {2'h0, pa});
        send_str("R1X");
        exp_s = nxt(exp_s, "R", 4'h1);
        chk_set(settings, exp_s);
        reg_write(bci_pkg::REG_ADDR, 32'h1F);
        reg_read(bci_pkg::REG_ADDR);
        chk_val(rd, 32'h1E);
        reg_read(4'hF);
        chk_val(rd, 32'h0);
    endtask

    task automatic t_talk;
        string e = "NDCV+1.238975E+00\r\n";
        logic [7:0] got [19];
        bit ok;
        bci_ctl_i.put_byte(1'b1, bci_pkg::TAD_BASE | {2'h0, pa});
        bci_ctl_i.get_bytes(got, ok);
        chk_val({31'h0, ok}, 32'h1);
        for (int i = 0; i < 19; i++) chk_val({24'h0, got[i]}, {24'h0, e[i]});
        reg_read(bci_pkg::REG_STATUS);
        chk_val(rd, 32'h3);
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Reset for four cycles, check power-up state, then run the scenarios
    initial begin
        exp_s = bci_pkg::SET_RST;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk_set(settings, exp_s);
        chk_val(rel_value, 32'h0);
        reg_read(bci_pkg::REG_ADDR);
        chk_val(rd, 32'h7);
        bci_ctl_i.put_byte(1'b1, bci_pkg::LAD_BASE | 7'h07);
        t_exec();
        t_codes();
        t_rel();
        t_err();
        t_addr();
        t_talk();
        print_verdict();
    end
endmodule

`default_nettype wire
